// ---- rtl/prs_host_seq.sv ----
// Purpose: host-side driver of reset and chip select
// Assumes: user requests held until granted
// Notes: contents are flagged lost after each reset pulse
`default_nettype none
module prs_host_seq
  import prs_pkg::*;
#(
  parameter int INIT_CYC = POWER_UP_INIT_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Reset, active high
  prs_link_if.host link, // Reset and select to memory
  input wire logic hw_reset_req, // Pulse a hardware reset
  input wire logic sel_req, // Want chip select low
  output logic sel_ok, // Select may be asserted
  output logic data_lost // Reload array contents
);
  localparam int CW = $clog2(INIT_CYC + RESET_ASSERT_TO_SELECT_CYC + 1);
  prs_host_state_t state;
  logic [CW-1:0] cnt, since_fall;
  logic first_up;
  wire logic pulse_done = (cnt >= CW'(RESET_PULSE_MIN_CYC - 1));
  // Power-up waits the init time, later resets the recovery times
  wire logic wait_done = first_up ? (cnt >= CW'(INIT_CYC - 1)) :
    ((cnt >= CW'(RESET_RELEASE_TO_SELECT_CYC - 1)) &&
     (since_fall >= CW'(RESET_ASSERT_TO_SELECT_CYC - 1)));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= PRS_HOST_WAIT;
      cnt <= '0;
      since_fall <= '0;
      first_up <= 1'b1;
      link.reset_n <= 1'b1;
      link.cs_n <= 1'b1;
      sel_ok <= 1'b0;
      data_lost <= 1'b0;
    end else begin
      if (since_fall != '1) since_fall <= since_fall + 1'b1;
      case (state)
        PRS_HOST_RESET: begin
          link.cs_n <= 1'b1;
          cnt <= cnt + 1'b1;
          if (pulse_done) begin
            link.reset_n <= 1'b1;
            cnt <= '0;
            state <= PRS_HOST_WAIT;
          end
        end
        PRS_HOST_WAIT: begin
          cnt <= cnt + 1'b1;
          if (wait_done) begin
            first_up <= 1'b0;
            sel_ok <= 1'b1;
            state <= PRS_HOST_READY;
          end
        end
        PRS_HOST_READY: begin
          link.cs_n <= ~sel_req;
          if (hw_reset_req) begin
            link.reset_n <= 1'b0;
            link.cs_n <= 1'b1;
            sel_ok <= 1'b0;
            data_lost <= 1'b1;
            cnt <= '0;
            since_fall <= '0;
            state <= PRS_HOST_RESET;
          end else if (sel_req) begin
            data_lost <= 1'b0;
          end
        end
        default: state <= PRS_HOST_WAIT;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- rtl/prs_link_if.sv ----
// Purpose: reset and chip select wires between host and memory
// Assumes: both ends on clk_sys
// Notes: both signals active low
`default_nettype none
interface prs_link_if;
  logic reset_n;
  logic cs_n;
  modport host (output reset_n, output cs_n);
  modport mem (input reset_n, input cs_n);
endinterface
`default_nettype wire

// ---- rtl/prs_mem_seq.sv ----
// Purpose: memory-side power-up and hardware reset sequencing
// Assumes: link reset_n acts asynchronously, no clock needed
// Notes: select during init or standby is ignored and flagged
`default_nettype none
module prs_mem_seq
  import prs_pkg::*;
#(
  parameter int INIT_CYC = POWER_UP_INIT_CYC,
  parameter int ROW_W = 12
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Power-on reset, active high
  prs_link_if.mem link, // Reset and select from host
  input wire logic dpd_enter, // Request deep power down
  input wire logic [7:0] cfg_wdata, // Configuration write data
  input wire logic cfg_we, // Configuration write strobe
  output logic ready, // Accepting transactions
  output logic init_busy, // Self-init running
  output logic refresh_on, // Self-refresh running
  output logic dpd, // In deep power down
  output logic [7:0] cfg, // Configuration register
  output logic [ROW_W-1:0] refresh_row, // Refresh row counter
  output logic access_err // Select seen while not ready
);
  prs_mem_state_t state, next_state;
  logic [$clog2(INIT_CYC+RESET_RELEASE_TO_SELECT_CYC+1)-1:0] init_cnt;
  logic powered_up;
  wire logic in_reset = rst | ~link.reset_n;
  // Full init only after power-up; a later pin reset needs only recovery
  wire logic [$bits(init_cnt)-1:0] init_last = powered_up ?
    ($bits(init_cnt))'(RESET_RELEASE_TO_SELECT_CYC - 1) : ($bits(init_cnt))'(INIT_CYC - 1);
  wire logic init_done = (init_cnt == init_last);
  wire logic sel = ~link.cs_n;

  always_comb begin
    next_state = state;
    case (state)
      PRS_MEM_STANDBY: next_state = PRS_MEM_INIT;
      PRS_MEM_INIT: if (init_done) next_state = PRS_MEM_READY;
      PRS_MEM_READY: if (dpd_enter && !sel) next_state = PRS_MEM_DPD;
      PRS_MEM_DPD: next_state = PRS_MEM_DPD;
      default: next_state = PRS_MEM_STANDBY;
    endcase
  end

  // Survives pin resets, so only the first release pays the init time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      powered_up <= 1'b0;
    end else if (state == PRS_MEM_READY) begin
      powered_up <= 1'b1;
    end
  end

  // Reset wins over everything, including deep power down
  always_ff @(posedge clk_sys or posedge in_reset) begin
    if (in_reset) begin
      state <= PRS_MEM_STANDBY;
      init_cnt <= '0;
    end else begin
      state <= next_state;
      init_cnt <= (state == PRS_MEM_INIT) ? init_cnt + 1'b1 : '0;
    end
  end

  always_ff @(posedge clk_sys or posedge in_reset) begin
    if (in_reset) begin
      cfg <= CFG_DEFAULT;
      refresh_row <= ROW_DEFAULT[ROW_W-1:0];
      refresh_on <= 1'b0;
      ready <= 1'b0;
      init_busy <= 1'b0;
      dpd <= 1'b0;
      access_err <= 1'b0;
    end else begin
      // Refresh resumes once released; init time is mostly refresh
      refresh_on <= (next_state != PRS_MEM_DPD);
      if (refresh_on) begin
        refresh_row <= refresh_row + 1'b1;
      end
      if (cfg_we && state == PRS_MEM_READY && sel) begin
        cfg <= cfg_wdata;
      end
      ready <= (next_state == PRS_MEM_READY);
      init_busy <= (next_state == PRS_MEM_INIT);
      dpd <= (next_state == PRS_MEM_DPD);
      access_err <= sel && (state != PRS_MEM_READY);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/prs_pkg.sv ----
// Purpose: constants shared by the memory-side and host-side reset sequencers
// Assumes: one 125 MHz clock, 8 ns period
// Notes: long counts are shortened through module parameters in simulation
// Operation
// - Self-init waits until reset input released
// - Host keeps select high during self-init
// - Init refreshes array, then accepts transactions
// - Reset returns memory to standby, no access
// - Reset loads configuration defaults
// - Self-refresh halted while reset low
// - Reset clears refresh row counter
// - Reset forces exit from deep power down
// - Host holds reset low at least 200 ns
// - Host waits 200 ns after release
// - Host waits 400 ns from reset fall
// - Host treats array contents lost after reset
`default_nettype none
package prs_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int POWER_UP_INIT_TIME_US = 150;
  localparam int RESET_PULSE_MIN_NS = 200;
  localparam int RESET_RELEASE_TO_SELECT_NS = 200;
  localparam int RESET_ASSERT_TO_SELECT_NS = 400;
  // Least times round up
  localparam int POWER_UP_INIT_CYC =
    (POWER_UP_INIT_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_PULSE_MIN_CYC =
    (RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_RELEASE_TO_SELECT_CYC =
    (RESET_RELEASE_TO_SELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_ASSERT_TO_SELECT_CYC =
    (RESET_ASSERT_TO_SELECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] CFG_DEFAULT = 8'h8F;
  localparam logic [11:0] ROW_DEFAULT = 12'h000;
  typedef enum logic [1:0] {
    PRS_MEM_STANDBY = 2'b00,
    PRS_MEM_INIT = 2'b01,
    PRS_MEM_READY = 2'b10,
    PRS_MEM_DPD = 2'b11
  } prs_mem_state_t;
  typedef enum logic [1:0] {
    PRS_HOST_RESET = 2'b00,
    PRS_HOST_WAIT = 2'b01,
    PRS_HOST_READY = 2'b10
  } prs_host_state_t;
endpackage
`default_nettype wire

// ---- sim/prs_assertions.sv ----
// Purpose: link reset and select timing
// Assumes: clk_sys only, rst async high
// Notes: hi_cnt and fa_cnt saturate, lo_cnt wraps
`default_nettype none
module prs_assertions
  import prs_pkg::*;
#(parameter int INIT_CYC = 40) (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic reset_n, // Link reset
  input wire logic cs_n // Link select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lo_cnt, hi_cnt, fa_cnt;
  logic pulsed;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      fa_cnt <= 16'hFFFF;
      pulsed <= 1'b0;
    end else begin
      lo_cnt <= reset_n ? 16'h0000 : lo_cnt + 16'h0001;
      hi_cnt <= reset_n ? hi_cnt + 16'(!(&hi_cnt)) : 16'h0000;
      fa_cnt <= (!reset_n && lo_cnt == 16'h0000) ? 16'h0001 : fa_cnt + 16'(!(&fa_cnt));
      pulsed <= pulsed | !reset_n;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_pulse; $rose(reset_n) |-> lo_cnt == RESET_PULSE_MIN_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  property p_hold; $fell(reset_n) |=> !reset_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset pulse cut");
  property p_quiet; !reset_n |-> cs_n; endproperty
  a_quiet: assert property (p_quiet) else $error("select in reset");
  property p_rel; $fell(cs_n) |-> hi_cnt >= RESET_RELEASE_TO_SELECT_CYC; endproperty
  a_rel: assert property (p_rel) else $error("select soon after release");
  property p_fall; $fell(cs_n) |-> fa_cnt >= RESET_ASSERT_TO_SELECT_CYC; endproperty
  a_fall: assert property (p_fall) else $error("select soon after fall");
  property p_init; $fell(cs_n) && !pulsed |-> hi_cnt >= INIT_CYC; endproperty
  a_init: assert property (p_init) else $error("select during init");
  c_pulse: cover property ($rose(reset_n));
  c_sel: cover property ($fell(cs_n) && !pulsed);
  c_resel: cover property ($fell(cs_n) && pulsed);
endmodule
`default_nettype wire

// ---- sim/psram_power_up_and_reset_sequencer_bench.sv ----
// Purpose: host and memory sequencers joined
// Assumes: init count cut to 40 cycles
// Notes: inputs move on falling edges
`default_nettype none
module psram_power_up_and_reset_sequencer_bench
  import prs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 40;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hw_reset_req = 1'b0;
  logic sel_req = 1'b0;
  logic dpd_enter = 1'b0;
  logic cfg_we = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg;
  logic [11:0] refresh_row, row0;
  logic ready, init_busy, refresh_on, dpd, access_err, sel_ok, data_lost;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  prs_link_if link ();
  always #4 clk_sys = ~clk_sys;
  prs_mem_seq #(.INIT_CYC(INIT)) u_prs_mem_seq (.clk_sys, .rst, .link, .dpd_enter,
    .cfg_wdata, .cfg_we, .ready, .init_busy, .refresh_on, .dpd, .cfg, .refresh_row, .access_err);
  prs_host_seq #(.INIT_CYC(INIT)) u_prs_host_seq (.clk_sys, .rst, .link, .hw_reset_req,
    .sel_req, .sel_ok, .data_lost);
  prs_assertions #(.INIT_CYC(INIT)) u_prs_assertions (.clk_sys, .rst,
    .reset_n(link.reset_n), .cs_n(link.cs_n));
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk1(input string s, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chkv(input string s, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  function automatic logic [11:0] adv(input logic [11:0] r, input int k);
    return r + 12'(k);
  endfunction
  task automatic results();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(8 * 3000);
    error_cnt++;
    results();
  end
  initial begin
    n = $urandom(75);
    cyc(4);
    rst = 1'b0;
    cyc(INIT);
    chk1("ready", 1'b0, ready);
    chk1("busy", 1'b1, init_busy);
    cyc(2);
    chk1("ready", 1'b1, ready);
    for (int r = 0; r < 3; r++) begin
      sel_req = 1'b1;
      for (n = 0; n < 200 && link.cs_n !== 1'b0; n++) cyc(1);
      cyc(1);
      chk1("err", 1'b0, access_err);
      for (n = 0; n < 200 && ready !== 1'b1; n++) cyc(1);
      chk1("lost", 1'b0, data_lost);
      cfg_wdata = 8'($urandom);
      cfg_we = 1'b1;
      cyc(2);
      cfg_we = 1'b0;
      chkv("cfg", {4'h0, cfg_wdata}, {4'h0, cfg});
      row0 = refresh_row;
      cyc(5);
      chkv("row", adv(row0, 5), refresh_row);
      sel_req = 1'b0;
      cyc(2);
      dpd_enter = 1'b1;
      cyc(2);
      dpd_enter = 1'b0;
      chk1("dpd", 1'b1, dpd);
      hw_reset_req = 1'b1;
      cyc(1);
      hw_reset_req = 1'b0;
      chk1("dpd", 1'b0, dpd);
      chk1("ready", 1'b0, ready);
      chkv("cfg", {4'h0, CFG_DEFAULT}, {4'h0, cfg});
      chkv("row", ROW_DEFAULT, refresh_row);
      chk1("refresh", 1'b0, refresh_on);
      chk1("lost", 1'b1, data_lost);
      for (n = 0; n < 99 && link.reset_n === 1'b0; n++) cyc(1);
      chkv("pulse", 12'(RESET_PULSE_MIN_CYC), 12'(n));
      cyc(1);
      chk1("refresh", 1'b1, refresh_on);
    end
    results();
  end
endmodule
`default_nettype wire
